// ===== rtl/wanc_top.sv
`timescale 1ns/100ps
`default_nettype none
module wanc_top #(
  parameter int unsigned HOLD_CYCLES = wanc_pkg::HOLD_CYCLES,
  parameter logic [15:0] ALARM_CODE_BASE = 16'h0100 // arbitrary base for alarm codes
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic signed [wanc_pkg::TEMP_W-1:0] measured_temperature_i,
  input wire wanc_pkg::wanc_band_t input_range_i,
  input wire wanc_pkg::wanc_band_t process_limits_i,
  input wire wanc_pkg::wanc_band_t [wanc_pkg::ALERT_CHANNELS-1:0] alert_band_i,
  input wire wanc_pkg::wanc_rate_t rate_i,
  input wire logic loop_break_cause_i,
  input wire logic minor_cause_i,
  input wire logic [wanc_pkg::CODE_W-1:0] minor_code_i,
  input wire logic major_error_i,
  input wire logic error_clear_req_i,
  input wire logic [wanc_pkg::STATION_W-1:0] station_switch_i,
  output logic warning_flag_input_o,
  output logic [wanc_pkg::CODE_W-1:0] latest_warning_code_word_o,
  output logic error_flag_input_o,
  output logic fault_indicator_o,
  output logic [wanc_pkg::NUM_ALARMS-1:0] alarm_o
);
  import wanc_pkg::*;

  logic rst_meta, rst_n;
  logic [STATION_W-1:0] sta_meta, sta_sync, sta_ref, next_sta_ref;
  logic ref_valid, next_ref_valid;
  logic station_changed, station_q, minor_q, next_station_q, next_minor_q;
  logic station_rise, minor_rise, warn_cause;
  logic [NUM_ALARMS-1:0] cond, alarm_rise;
  logic [NUM_ALARMS-1:0] next_alarm;
  logic [CODE_W-1:0] next_code, alarm_code;
  logic next_warn_flag, next_err_flag, next_fault;
  logic warn_pending, warn_expire;
  logic signed [TEMP_W:0] rate_lim;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // station selector is a pin, so two flops; no reset keeps it valid at release
  always_ff @(posedge core_clk_i) begin
    sta_meta <= station_switch_i;
    sta_sync <= sta_meta;
  end

  // reference station number caught once, right after reset release
  // a selector moved while in reset becomes the new reference, not a warning
  always_comb begin
    next_ref_valid = 1'b1;
    next_sta_ref = ref_valid ? sta_ref : sta_sync;
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ref_valid <= 1'b0;
      sta_ref <= STATION_NONE;
    end else begin
      ref_valid <= next_ref_valid;
      sta_ref <= next_sta_ref;
    end
  end

  // a changed selector stays a cause until it is set back
  assign station_changed = ref_valid && (sta_sync != sta_ref);

  // alarm conditions from the temperature, its limits, the rate input and the loop break cause
  assign rate_lim = $signed({2'b00, rate_i.limit});
  always_comb begin
    cond = ALARMS_NONE;
    cond[ALM_OVER] = measured_temperature_i > input_range_i.hi;
    cond[ALM_UNDER] = measured_temperature_i < input_range_i.lo;
    cond[ALM_LOOP] = loop_break_cause_i;
    for (int i = 0; i < ALERT_CHANNELS; i++) begin
      cond[ALM_ALERT0 + i] = (measured_temperature_i > alert_band_i[i].hi) ||
                             (measured_temperature_i < alert_band_i[i].lo);
    end
    cond[ALM_PROC_HI] = measured_temperature_i > process_limits_i.hi;
    cond[ALM_PROC_LO] = measured_temperature_i < process_limits_i.lo;
    cond[ALM_RATE_UP] = TEMP_W'(rate_i.delta) > rate_lim;
    cond[ALM_RATE_DN] = TEMP_W'(rate_i.delta) < -rate_lim;
  end

  // alarms follow their condition, so they clear by themselves
  assign next_alarm = cond;
  assign alarm_rise = cond & ~alarm_o;

  // lowest alarm index wins when several appear together
  always_comb begin
    alarm_code = CODE_NONE;
    for (int i = NUM_ALARMS - 1; i >= 0; i--) begin
      if (alarm_rise[i]) begin
        alarm_code = ALARM_CODE_BASE + CODE_W'(i);
      end
    end
  end

  // warning causes and their rising edges
  assign warn_cause = minor_cause_i | station_changed;
  assign station_rise = station_changed & ~station_q;
  assign minor_rise = minor_cause_i & ~minor_q;

  wanc_hold_timer #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_hold (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .cause_i(warn_cause),
    .pending_o(warn_pending),
    .expire_o(warn_expire)
  );

  // notification next values; a new occurrence beats a clear in the same cycle
  always_comb begin
    next_station_q = station_changed;
    next_minor_q = minor_cause_i;
    next_code = latest_warning_code_word_o;
    if (station_rise) begin
      next_code = STATION_CHANGE_CODE;
    end else if (minor_rise) begin
      next_code = minor_code_i;
    end else if (|alarm_rise) begin
      next_code = alarm_code;
    end else if (warn_expire) begin
      next_code = CODE_NONE;
    end
    // flag covers warnings in their delay and live alarms
    next_warn_flag = warn_pending | warn_cause | (|cond);
    next_err_flag = major_error_i | (error_flag_input_o & ~error_clear_req_i);
    // led stays lit through the delay and while an error is flagged, dark once both end
    next_fault = warn_pending | warn_cause | next_err_flag;
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      station_q <= 1'b0;
      minor_q <= 1'b0;
      alarm_o <= ALARMS_NONE;
      latest_warning_code_word_o <= CODE_NONE;
      warning_flag_input_o <= 1'b0;
      error_flag_input_o <= 1'b0;
      fault_indicator_o <= 1'b0;
    end else begin
      station_q <= next_station_q;
      minor_q <= next_minor_q;
      alarm_o <= next_alarm;
      latest_warning_code_word_o <= next_code;
      warning_flag_input_o <= next_warn_flag;
      error_flag_input_o <= next_err_flag;
      fault_indicator_o <= next_fault;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  sequence minor_appears;
    minor_cause_i && !minor_q;
  endsequence

  sequence quiet_expiry;
    warn_expire && !(|alarm_rise) && !station_rise && !minor_rise;
  endsequence

  warn_flag_a: assert property (minor_appears |=> warning_flag_input_o)
    else $error("warning flag missing after minor error");
  minor_code_a: assert property (minor_appears and !station_rise
      |=> latest_warning_code_word_o == $past(minor_code_i))
    else $error("minor error code not stored");
  station_code_a: assert property (station_rise |=> latest_warning_code_word_o == STATION_CHANGE_CODE)
    else $error("station change code not stored");
  code_clear_a: assert property (quiet_expiry |=> latest_warning_code_word_o == CODE_NONE)
    else $error("warning code not zeroed at expiry");
  code_zero_alarm_a: assert property (quiet_expiry and (|alarm_o)
      |=> latest_warning_code_word_o == CODE_NONE && $past(|alarm_o))
    else $error("code kept while old alarm active");
  flag_clear_a: assert property (quiet_expiry and !warn_cause and !(|cond)
      and !major_error_i and !error_flag_input_o
      |=> !warning_flag_input_o && !fault_indicator_o)
    else $error("flag or led still on after expiry");
  range_alarm_a: assert property (!cond[ALM_OVER] && !cond[ALM_UNDER]
      |=> !alarm_o[ALM_OVER] && !alarm_o[ALM_UNDER])
    else $error("range alarm not dropped");
  loop_alarm_a: assert property ($fell(loop_break_cause_i) |-> ##1 !alarm_o[ALM_LOOP])
    else $error("loop break alarm not dropped");
  alert_alarm_a: assert property (cond[ALM_ALERT0 +: ALERT_CHANNELS] == '0
      |=> alarm_o[ALM_ALERT0 +: ALERT_CHANNELS] == '0)
    else $error("alert alarm not dropped");
  proc_alarm_a: assert property (!cond[ALM_PROC_HI] && !cond[ALM_PROC_LO]
      |=> !alarm_o[ALM_PROC_HI] && !alarm_o[ALM_PROC_LO])
    else $error("process alert not dropped");
  rate_alarm_a: assert property (!cond[ALM_RATE_UP] ##1 !cond[ALM_RATE_UP] |=> !alarm_o[ALM_RATE_UP])
    else $error("rate alert not dropped");
  err_clear_a: assert property (error_clear_req_i && !major_error_i |=> !error_flag_input_o)
    else $error("error flag survived clear request");
  err_set_a: assert property (major_error_i |=> error_flag_input_o && fault_indicator_o)
    else $error("error flag missing after major error");

  // notification follow-ups as seen on the outputs
  alarm_code_a: assert property (alarm_rise[ALM_OVER] && !station_rise && !minor_rise
      |=> latest_warning_code_word_o == ALARM_CODE_BASE)
    else $error("alarm code not stored for lowest new alarm");
  warn_hold_a: assert property (warn_pending |=> warning_flag_input_o && fault_indicator_o)
    else $error("flag or led dropped during clear delay");
  alarm_flag_a: assert property (|alarm_o |-> warning_flag_input_o)
    else $error("warning flag low while an alarm stands");
  station_flag_a: assert property (station_rise |=> warning_flag_input_o && fault_indicator_o)
    else $error("station change not flagged");
  led_expiry_a: assert property (warn_expire && !warn_cause && !major_error_i && !error_flag_input_o
      |=> !fault_indicator_o)
    else $error("fault indicator still lit after expiry");
endmodule
`default_nettype wire

// ===== pkg/wanc_pkg.sv
package wanc_pkg;

  // timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned HOLD_TIME_S = 5;
  localparam int unsigned HOLD_CYCLES = HOLD_TIME_S * CLK_HZ;

  // widths
  localparam int TEMP_W = 16;
  localparam int CODE_W = 16;
  localparam int STATION_W = 8;
  localparam int ALERT_CHANNELS = 4;
  localparam int NUM_ALARMS = 11;

  // alarm bit positions
  localparam int ALM_OVER = 0;
  localparam int ALM_UNDER = 1;
  localparam int ALM_LOOP = 2;
  localparam int ALM_ALERT0 = 3;
  localparam int ALM_PROC_HI = 7;
  localparam int ALM_PROC_LO = 8;
  localparam int ALM_RATE_UP = 9;
  localparam int ALM_RATE_DN = 10;

  // codes and reset values
  localparam logic [CODE_W-1:0] STATION_CHANGE_CODE = 16'h0940;
  localparam logic [CODE_W-1:0] CODE_NONE = 16'h0000;
  localparam logic [NUM_ALARMS-1:0] ALARMS_NONE = 11'h000;
  localparam logic [STATION_W-1:0] STATION_NONE = 8'h00;

  typedef struct packed {
    logic signed [TEMP_W-1:0] lo;
    logic signed [TEMP_W-1:0] hi;
  } wanc_band_t;

  typedef struct packed {
    logic signed [TEMP_W-1:0] delta;
    logic [TEMP_W-2:0] limit;
  } wanc_rate_t;

  typedef enum logic [1:0] {
    HOLD_IDLE = 2'b00,
    HOLD_ACTIVE = 2'b01,
    HOLD_WAIT = 2'b11
  } wanc_hold_state_t;

endpackage

// ===== rtl/wanc_hold_timer.sv
`timescale 1ns/100ps
`default_nettype none
module wanc_hold_timer #(
  parameter int unsigned HOLD_CYCLES = wanc_pkg::HOLD_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cause_i,
  output logic pending_o,
  output logic expire_o
);
  import wanc_pkg::*;

  localparam int CNT_W = $clog2(HOLD_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HOLD_CYCLES - 1);

  wanc_hold_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic next_pending, next_expire;

  // delay starts at the falling cause and restarts if it comes back
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_expire = 1'b0;
    case (state)
      HOLD_IDLE: begin
        if (cause_i) begin
          next_state = HOLD_ACTIVE;
        end
      end
      HOLD_ACTIVE: begin
        if (!cause_i) begin
          next_state = HOLD_WAIT;
          next_cnt = '0;
        end
      end
      HOLD_WAIT: begin
        if (cause_i) begin
          next_state = HOLD_ACTIVE;
        end else if (cnt == CNT_LAST) begin
          next_state = HOLD_IDLE;
          next_expire = 1'b1;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      default: begin
        next_state = HOLD_IDLE;
      end
    endcase
    next_pending = (next_state != HOLD_IDLE);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= HOLD_IDLE;
      cnt <= '0;
      pending_o <= 1'b0;
      expire_o <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pending_o <= next_pending;
      expire_o <= next_expire;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  hold_restart_a: assert property (state == HOLD_WAIT && cause_i |=> state == HOLD_ACTIVE && !expire_o)
    else $error("returning cause did not restart the clear delay");
  hold_expiry_a: assert property (state == HOLD_WAIT && cnt == CNT_LAST && !cause_i
      |=> expire_o && !pending_o && state == HOLD_IDLE)
    else $error("clear delay did not expire on its last count");
  hold_early_a: assert property (cause_i |=> !expire_o ##1 !expire_o)
    else $error("warning expired while its cause was present");
endmodule
`default_nettype wire

// ===== testbench/wanc_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// master side: turns a command level into a single-cycle error clear request
module wanc_master_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_cmd_i,
  output logic error_clear_req_o
);
  logic cmd_q;
  logic next_cmd_q;
  logic next_req;
  // edge detect so a held command still sends one request
  always_comb begin
    next_cmd_q = clear_cmd_i;
    next_req = clear_cmd_i & ~cmd_q;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_q <= 1'b0;
      error_clear_req_o <= 1'b0;
    end else begin
      cmd_q <= next_cmd_q;
      error_clear_req_o <= next_req;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/warning_alarm_notify_clear_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module warning_alarm_notify_clear_tb_top;
  import wanc_pkg::*;
  localparam int unsigned HOLD = 20;
  localparam logic [15:0] BASE = 16'h0100;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic signed [TEMP_W-1:0] temp = '0;
  wanc_band_t in_rng = '{-16'sd50, 16'sd50};
  wanc_band_t plim = '{-16'sd30, 16'sd30};
  wanc_band_t [ALERT_CHANNELS-1:0] abnd = '0;
  wanc_rate_t rate = '0;
  logic loop_brk = 1'b0;
  logic minor = 1'b0;
  logic [CODE_W-1:0] mcode = '0;
  logic major = 1'b0;
  logic clear_cmd = 1'b0;
  logic clr_req;
  logic [STATION_W-1:0] station = 8'h03;
  logic wflag;
  logic [CODE_W-1:0] wcode;
  logic eflag;
  logic fault;
  logic [NUM_ALARMS-1:0] alarm;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  int n;

  wanc_top #(.HOLD_CYCLES(HOLD), .ALARM_CODE_BASE(BASE)) DUT (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .measured_temperature_i(temp),
    .input_range_i(in_rng), .process_limits_i(plim), .alert_band_i(abnd), .rate_i(rate),
    .loop_break_cause_i(loop_brk), .minor_cause_i(minor), .minor_code_i(mcode),
    .major_error_i(major), .error_clear_req_i(clr_req), .station_switch_i(station),
    .warning_flag_input_o(wflag), .latest_warning_code_word_o(wcode),
    .error_flag_input_o(eflag), .fault_indicator_o(fault), .alarm_o(alarm));
  wanc_master_model master (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .clear_cmd_i(clear_cmd),
    .error_clear_req_o(clr_req));

  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      error_cnt++;
      $display("unexpected at %0t: timeout", $time);
      close_out();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask

  // counts edges until the code word is back to zero
  task automatic wait_clear(output int c);
    c = 0;
    while (wcode !== CODE_NONE && c < HOLD + 10) begin
      step(1);
      c++;
    end
  endtask

  function automatic logic [NUM_ALARMS-1:0] exp_alarm(input logic signed [TEMP_W-1:0] t);
    logic [NUM_ALARMS-1:0] a;
    a = '0;
    a[ALM_OVER] = t > in_rng.hi;
    a[ALM_UNDER] = t < in_rng.lo;
    a[ALM_LOOP] = loop_brk;
    for (int i = 0; i < ALERT_CHANNELS; i++) a[ALM_ALERT0+i] = t < abnd[i].lo || t > abnd[i].hi;
    a[ALM_PROC_HI] = t > plim.hi;
    a[ALM_PROC_LO] = t < plim.lo;
    a[ALM_RATE_UP] = rate.delta > $signed({1'b0, rate.limit});
    a[ALM_RATE_DN] = rate.delta < -$signed({1'b0, rate.limit});
    return a;
  endfunction

  initial begin
    void'($urandom(13821));
    step(2);
    chk({wflag, wcode, eflag, fault, alarm}, '0);
    @(posedge core_clk_i);
    @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rate.limit <= 15'd30;
    step(4);
    // random alarm traffic; every tenth sample sits exactly on the range edge
    for (int k = 0; k < 150; k++) begin
      @(posedge core_clk_i);
      temp <= (k % 10 == 0) ? in_rng.hi : 16'($urandom_range(200)) - 16'd100;
      loop_brk <= 1'($urandom_range(1));
      rate.delta <= 16'($urandom_range(120)) - 16'd60;
      for (int i = 0; i < ALERT_CHANNELS; i++) begin
        abnd[i].lo <= 16'($urandom_range(60)) - 16'd80;
        abnd[i].hi <= 16'($urandom_range(100)) - 16'd20;
      end
      step(1);
      chk(alarm, exp_alarm(temp));
      chk(wflag, |exp_alarm(temp));
    end
    $display("test random alarms done");
    @(posedge core_clk_i);
    temp <= '0;
    loop_brk <= 1'b0;
    rate.delta <= '0;
    for (int i = 0; i < ALERT_CHANNELS; i++) begin
      abnd[i] <= '{-16'sd1000, 16'sd1000};
    end
    step(3);
    @(posedge core_clk_i);
    temp <= 16'sd60;
    step(1);
    chk(wcode, BASE);
    @(posedge core_clk_i);
    temp <= 16'sd40;
    step(1);
    chk(alarm, 11'h080);
    @(posedge core_clk_i);
    minor <= 1'b1;
    mcode <= 16'h0A5C;
    step(2);
    chk({wflag, fault, wcode}, {2'b11, 16'h0A5C});
    @(posedge core_clk_i);
    minor <= 1'b0;
    wait_clear(n);
    chk(n >= HOLD + 1 && n <= HOLD + 4, 1);
    chk({wcode, alarm}, {CODE_NONE, 11'h080});
    chk({wflag, fault}, 2'b10);
    $display("test warning under alarm done");
    @(posedge core_clk_i);
    temp <= '0;
    mcode <= 16'h0B17;
    minor <= 1'b1;
    step(2);
    @(posedge core_clk_i);
    minor <= 1'b0;
    step(10);
    chk(wflag, 1);
    @(posedge core_clk_i);
    minor <= 1'b1;
    step(3);
    @(posedge core_clk_i);
    minor <= 1'b0;
    wait_clear(n);
    chk(n >= HOLD + 1 && n <= HOLD + 4, 1);
    chk({wflag, fault}, 2'b00);
    $display("test restart done");
    @(posedge core_clk_i);
    station <= 8'h05;
    n = 0;
    while (wcode !== STATION_CHANGE_CODE && n < 8) begin
      step(1);
      n++;
    end
    chk({wflag, wcode}, {1'b1, STATION_CHANGE_CODE});
    @(posedge core_clk_i);
    station <= 8'h03;
    wait_clear(n);
    chk(n >= HOLD + 1 && n <= HOLD + 6, 1);
    chk(wflag, 0);
    $display("test station change done");
    @(posedge core_clk_i);
    major <= 1'b1;
    @(posedge core_clk_i);
    major <= 1'b0;
    step(4);
    chk({eflag, fault, wflag}, 3'b110);
    @(posedge core_clk_i);
    clear_cmd <= 1'b1;
    @(posedge core_clk_i);
    clear_cmd <= 1'b0;
    step(3);
    chk({eflag, fault}, 2'b00);
    $display("test error clear done");
    close_out();
  end
endmodule
`default_nettype wire
